// file: hw/mps_dummy_end.sv
`timescale 1ns/1ps
`default_nettype none
`default_nettype wire

// file: hw/mps_flags.sv
`timescale 1ns/1ps
`default_nettype none
`include "mps_map.svh"
module mps_flags
  import mps_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic clr_sticky,
  input wire logic [2:0] proto_evt,
  input wire logic alarm_lvl,
  input wire logic [7:0] crit_lvl,
  input wire logic swap_evt,
  input wire logic desync_lvl,
  input wire logic corr_en,
  output logic [`MPS_FLG_W-1:0] flags
);
  // protocol errors sticky, set beats clear
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      flags[`MPS_FLG_ALARM:0] <= 4'h0;
    end else begin
      flags[`MPS_FLG_ALARM:0] <= ({alarm_lvl, proto_evt})
        | (flags[`MPS_FLG_ALARM:0] & {4{!clr_sticky}});
    end
  end

  // critical flags follow their qualified levels
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      flags[`MPS_FLG_SWAP-1:`MPS_FLG_CRIT_LSB] <= 8'h0;
    end else begin
      flags[`MPS_FLG_SWAP-1:`MPS_FLG_CRIT_LSB] <= crit_lvl;
    end
  end

  // swap sticky, general error self-clears under correction
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      flags[`MPS_FLG_SWAP] <= 1'b0;
      flags[`MPS_FLG_GEN] <= 1'b0;
    end else begin
      flags[`MPS_FLG_SWAP] <= swap_evt | (flags[`MPS_FLG_SWAP] & !clr_sticky);
      flags[`MPS_FLG_GEN] <= desync_lvl | (flags[`MPS_FLG_GEN] & !clr_sticky & !corr_en);
    end
  end

  // sticky flag survives until fast stop
  AST_STICKY_HOLD: assert property (@(posedge hclk) disable iff (!hresetn)
    (flags[`MPS_FLG_ERRC] && !clr_sticky) |=> flags[`MPS_FLG_ERRC])
    else $error("sticky flag dropped without fast stop");
  AST_SWAP_HOLD: assert property (@(posedge hclk) disable iff (!hresetn)
    (flags[`MPS_FLG_SWAP] && !clr_sticky) |=> flags[`MPS_FLG_SWAP])
    else $error("swap flag cleared itself");
endmodule // mps_flags
`default_nettype wire

// file: hw/mps_map.svh
`ifndef MPS_MAP_SVH
`define MPS_MAP_SVH
// Register byte offsets
`define MPS_CMD_OFS 8'h00
`define MPS_CFG_OFS 8'h04
`define MPS_ARG_POS_OFS 8'h08
`define MPS_ARG_PRIMARY_MICROSTEP_COUNT_OFS 8'h0c
`define MPS_ARG_ENC_OFS 8'h10
`define MPS_ARG_IGN_OFS 8'h14
`define MPS_TARGET_OFS 8'h18
`define MPS_ST_MOVE_OFS 8'h20
`define MPS_ST_POS_OFS 8'h24
`define MPS_ST_PRIMARY_MICROSTEP_COUNT_OFS 8'h28
`define MPS_ST_SEC_OFS 8'h2c
`define MPS_ST_SPEED_OFS 8'h30
`define MPS_ST_USPEED_OFS 8'h34
`define MPS_ST_CUR_OFS 8'h38
`define MPS_ST_VOLT_OFS 8'h3c
`define MPS_ST_TEMP_OFS 8'h40
`define MPS_ST_FLAGS_OFS 8'h44
// Command register fields
`define MPS_CMD_CODE_MSB 3
`define MPS_CMD_BADCHK_BIT 8
// Config register fields
`define MPS_CFG_MODE_MSB 1
`define MPS_CFG_CORR_BIT 2
`define MPS_CFG_SPR_LSB 16
`define MPS_CFG_RST 32'h00c8_0000
// Ignore flag fields
`define MPS_IGN_POS_BIT 0
`define MPS_IGN_ENC_BIT 1
// Flag vector positions
`define MPS_FLG_ERRC 0
`define MPS_FLG_ERRD 1
`define MPS_FLG_ERRV 2
`define MPS_FLG_ALARM 3
`define MPS_FLG_CRIT_LSB 4
`define MPS_FLG_SWAP 12
`define MPS_FLG_GEN 13
`define MPS_FLG_W 14
// Encoder statistics: movement cycles a new state must persist
`define MPS_ENC_STATS 16'd64
`endif

// file: hw/mps_pkg.sv
package mps_pkg;
  typedef enum logic [3:0] {
    MPS_CMD_UNKNOWN = 4'h0, MPS_CMD_MOVE = 4'h1, MPS_CMD_RELATIVE_MOVE_CMD = 4'h2,
    MPS_CMD_RIGHT = 4'h3, MPS_CMD_LEFT = 4'h4, MPS_CMD_SSTOP = 4'h5,
    MPS_CMD_FSTOP = 4'h6, MPS_CMD_HOME = 4'h7, MPS_CMD_FBACK = 4'h8,
    MPS_CMD_ZERO = 4'h9, MPS_CMD_SET_POSITION_CMD = 4'ha, MPS_CMD_READ_STATUS_CMD = 4'hb
  } mps_cmd_e;
  typedef enum logic [1:0] {
    MPS_MODE_OPEN = 2'h0, MPS_MODE_LEADENC = 2'h1, MPS_MODE_ENCFB = 2'h2, MPS_MODE_DC = 2'h3
  } mps_mode_e;
  typedef enum logic [1:0] {
    MPS_PWR_OFF = 2'h0, MPS_PWR_REDUCED = 2'h1, MPS_PWR_NOMINAL = 2'h2, MPS_PWR_LOWV = 2'h3
  } mps_pwr_e;
  typedef enum logic [2:0] {
    MPS_ENC_ABSENT = 3'h0, MPS_ENC_UNKNOWN = 3'h1, MPS_ENC_OK = 3'h2,
    MPS_ENC_REVERSED = 3'h3, MPS_ENC_BAD = 3'h4
  } mps_enc_e;
  typedef enum logic [1:0] {
    MPS_WND_UNKNOWN = 2'h0, MPS_WND_OPEN = 2'h1, MPS_WND_OK = 2'h2, MPS_WND_SHORT = 2'h3
  } mps_wnd_e;
endpackage

// file: hw/mps_pos.sv
`timescale 1ns/1ps
`default_nettype none
module mps_pos
  import mps_pkg::*;
#(
  parameter int PRIMARY_MICROSTEP_COUNT_DIV = 256
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic primary_microstep_count_up,
  input wire logic primary_microstep_count_dn,
  input wire logic enc_up,
  input wire logic enc_dn,
  mps_pos_if.cnt pif
);
  localparam logic [15:0] UMAX = 16'(PRIMARY_MICROSTEP_COUNT_DIV - 1);

  // all counters zeroed together
  // Step and microstep counters
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pif.step_cnt <= 32'sh0;
      pif.primary_microstep_count_cnt <= 16'h0;
    end else if (pif.zero_req) begin
      pif.step_cnt <= 32'sh0;
      pif.primary_microstep_count_cnt <= 16'h0;
    end else if (pif.set_position_cmd_req && !pif.ign_pos) begin
      pif.step_cnt <= pif.new_step;
      pif.primary_microstep_count_cnt <= pif.new_primary_microstep_count;
    end else if (primary_microstep_count_up && !primary_microstep_count_dn) begin
      if (pif.primary_microstep_count_cnt == UMAX) begin
        pif.primary_microstep_count_cnt <= 16'h0;
        pif.step_cnt <= pif.step_cnt + 32'sh1;
      end else begin
        pif.primary_microstep_count_cnt <= pif.primary_microstep_count_cnt + 16'h1;
      end
    end else if (primary_microstep_count_dn && !primary_microstep_count_up) begin
      if (pif.primary_microstep_count_cnt == 16'h0) begin
        pif.primary_microstep_count_cnt <= UMAX;
        pif.step_cnt <= pif.step_cnt - 32'sh1;
      end else begin
        pif.primary_microstep_count_cnt <= pif.primary_microstep_count_cnt - 16'h1;
      end
    end
  end

  // Encoder counter
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pif.enc_cnt <= 32'sh0;
    end else if (pif.zero_req) begin
      pif.enc_cnt <= 32'sh0;
    end else if (pif.set_position_cmd_req && !pif.ign_enc) begin
      pif.enc_cnt <= pif.new_enc;
    end else if (enc_up && !enc_dn) begin
      pif.enc_cnt <= pif.enc_cnt + 32'sh1;
    end else if (enc_dn && !enc_up) begin
      pif.enc_cnt <= pif.enc_cnt - 32'sh1;
    end
  end

  AST_ZERO_ALL: assert property (@(posedge hclk) disable iff (!hresetn)
    pif.zero_req |=> (pif.step_cnt == 0 && pif.primary_microstep_count_cnt == 0 && pif.enc_cnt == 0))
    else $error("zero left a counter nonzero");
  AST_SET_POSITION_CMD_IGN: assert property (@(posedge hclk) disable iff (!hresetn)
    (pif.set_position_cmd_req && pif.ign_enc && !pif.zero_req && !enc_up && !enc_dn) |=> $stable(pif.enc_cnt))
    else $error("ignored encoder count changed");
endmodule // mps_pos
`default_nettype wire

// file: hw/mps_pos_if.sv
`timescale 1ns/1ps
`default_nettype none
interface mps_pos_if;
  logic zero_req;
  logic set_position_cmd_req;
  logic ign_pos;
  logic ign_enc;
  logic signed [31:0] new_step;
  logic [15:0] new_primary_microstep_count;
  logic signed [31:0] new_enc;
  logic signed [31:0] step_cnt;
  logic [15:0] primary_microstep_count_cnt;
  logic signed [31:0] enc_cnt;
  modport ctl (output zero_req, set_position_cmd_req, ign_pos, ign_enc, new_step, new_primary_microstep_count, new_enc,
               input step_cnt, primary_microstep_count_cnt, enc_cnt);
  modport cnt (input zero_req, set_position_cmd_req, ign_pos, ign_enc, new_step, new_primary_microstep_count, new_enc,
               output step_cnt, primary_microstep_count_cnt, enc_cnt);
endinterface // mps_pos_if
`default_nettype wire

// file: hw/mps_top.sv
// Overview of operation
// - set-zero clears all counters same cycle
// - set-zero mid-move keeps physical end point
// - relative shift destination unchanged by zeroing
// - set-position loads only non-ignored counters
// - set-position shifts target by the step jump, preserves end point
// - movement field: moving, speed reached, backlash
// - command field: last movement code plus running bit
// - result bit shows success or failure
// - reset reads unknown command, success
// - winding power has four states
// - encoder state has five codes
// - encoder change only after moving statistics
// - each winding open, ok, short, unknown
// - primary position per control mode
// - secondary position per motor type
// - telemetry in mA, 10 mV, 0.1 C
// - sticky flags cleared by fast stop
// - unknown, integrity, bad-value flags sticky
// - critical flags raised, mostly self-clearing
// - swapped limit flag always sticky
// - desync flag sticky unless correction on
//
// Decided for this implementation: the AHB-Lite slave port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
`include "mps_map.svh"
module mps_top
  import mps_pkg::*;
#(
  parameter int PRIMARY_MICROSTEP_COUNT_DIV = 256
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic primary_microstep_count_up,
  input wire logic primary_microstep_count_dn,
  input wire logic enc_up,
  input wire logic enc_dn,
  input wire logic moving,
  input wire logic speed_reached,
  input wire logic backlash_active,
  input wire logic move_done,
  input wire logic move_ok,
  input wire logic signed [31:0] speed_steps,
  input wire logic [15:0] speed_microsteps,
  input wire logic [1:0] winding_power_field,
  input wire logic [2:0] enc_candidate,
  input wire logic [1:0] wind_low_z,
  input wire logic [1:0] wind_high_r,
  input wire logic [1:0] wind_valid,
  input wire logic [15:0] sup_ma,
  input wire logic [15:0] usb_ma,
  input wire logic [15:0] sup_10mv,
  input wire logic [15:0] usb_10mv,
  input wire logic signed [15:0] cpu_decic,
  input wire logic alarm_lvl,
  input wire logic [7:0] crit_lvl,
  input wire logic swap_evt,
  input wire logic desync_lvl,
  output logic cmd_pulse,
  output logic [3:0] cmd_code,
  output logic signed [31:0] target,
  output logic [1:0] motor_mode,
  output logic [15:0] steps_per_rev
);
  mps_pos_if pif();

  logic [31:0] cfg;
  logic signed [31:0] arg_pos;
  logic [15:0] arg_primary_microstep_count;
  logic signed [31:0] arg_enc;
  logic [1:0] arg_ign;
  logic [7:0] wr_addr;
  logic wr_pend;
  logic cmd_wr;
  logic [3:0] new_code;
  logic bad_chk;
  logic code_ok;
  logic set_position_cmd_bad;
  logic cfg_bad;
  logic is_move;
  logic [2:0] proto_evt;
  logic [3:0] cmd_state;
  logic cmd_running;
  logic cmd_success;
  logic [2:0] enc_state;
  logic [2:0] enc_seen;
  logic [15:0] enc_cnt_stat;
  logic [3:0] wind_state;
  logic [`MPS_FLG_W-1:0] flags;
  logic signed [31:0] prim_pos;
  logic [15:0] prim_primary_microstep_count;
  logic signed [31:0] sec_pos;
  logic [31:0] snap_move;
  logic signed [31:0] snap_pos;
  logic [15:0] snap_primary_microstep_count;
  logic signed [31:0] snap_sec;
  logic signed [31:0] snap_speed;
  logic [15:0] snap_uspeed;
  logic [31:0] snap_cur;
  logic [31:0] snap_volt;
  logic signed [15:0] snap_temp;
  logic [`MPS_FLG_W-1:0] snap_flags;
  logic read_status_cmd_req;
  logic [31:0] next_rdata;

  // Zero-wait slave, always OKAY
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;

  // Write address phase capture
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend <= 1'b0;
      wr_addr <= 8'h0;
    end else if (hready) begin
      wr_pend <= hsel && htrans[1] && hwrite;
      wr_addr <= haddr[7:0];
    end
  end

  // Command decode from the data phase
  assign cmd_wr = wr_pend && (wr_addr == `MPS_CMD_OFS);
  assign new_code = hwdata[`MPS_CMD_CODE_MSB:0];
  assign bad_chk = hwdata[`MPS_CMD_BADCHK_BIT];
  assign code_ok = (new_code != MPS_CMD_UNKNOWN) && (new_code <= MPS_CMD_READ_STATUS_CMD);
  assign set_position_cmd_bad = arg_primary_microstep_count >= 16'(PRIMARY_MICROSTEP_COUNT_DIV);
  assign cfg_bad = wr_pend && (wr_addr == `MPS_CFG_OFS) && (hwdata[31:`MPS_CFG_SPR_LSB] == 16'h0);
  assign is_move = (new_code >= MPS_CMD_MOVE) && (new_code <= MPS_CMD_FBACK);

  assign proto_evt[`MPS_FLG_ERRC] = cmd_wr && !bad_chk && !code_ok;
  assign proto_evt[`MPS_FLG_ERRD] = cmd_wr && bad_chk;
  assign proto_evt[`MPS_FLG_ERRV] = (cmd_wr && !bad_chk && new_code == MPS_CMD_SET_POSITION_CMD && set_position_cmd_bad) || cfg_bad;

  // Requests toward the counters
  assign pif.zero_req = cmd_wr && !bad_chk && new_code == MPS_CMD_ZERO;
  assign pif.set_position_cmd_req = cmd_wr && !bad_chk && new_code == MPS_CMD_SET_POSITION_CMD && !set_position_cmd_bad;
  assign pif.ign_pos = arg_ign[`MPS_IGN_POS_BIT];
  assign pif.ign_enc = arg_ign[`MPS_IGN_ENC_BIT];
  assign pif.new_step = arg_pos;
  assign pif.new_primary_microstep_count = arg_primary_microstep_count;
  assign pif.new_enc = arg_enc;
  assign read_status_cmd_req = cmd_wr && !bad_chk && new_code == MPS_CMD_READ_STATUS_CMD;

  mps_pos #(.PRIMARY_MICROSTEP_COUNT_DIV(PRIMARY_MICROSTEP_COUNT_DIV)) u_pos (
    .hclk(hclk),
    .hresetn(hresetn),
    .primary_microstep_count_up(primary_microstep_count_up),
    .primary_microstep_count_dn(primary_microstep_count_dn),
    .enc_up(enc_up),
    .enc_dn(enc_dn),
    .pif(pif)
  );

  // Config and argument registers
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cfg <= `MPS_CFG_RST;
      arg_pos <= 32'sh0;
      arg_primary_microstep_count <= 16'h0;
      arg_enc <= 32'sh0;
      arg_ign <= 2'h0;
    end else if (wr_pend) begin
      case (wr_addr)
        `MPS_CFG_OFS: if (!cfg_bad) cfg <= hwdata;
        `MPS_ARG_POS_OFS: arg_pos <= hwdata;
        `MPS_ARG_PRIMARY_MICROSTEP_COUNT_OFS: arg_primary_microstep_count <= hwdata[15:0];
        `MPS_ARG_ENC_OFS: arg_enc <= hwdata;
        `MPS_ARG_IGN_OFS: arg_ign <= hwdata[1:0];
        default: ;
      endcase
    end
  end
  assign motor_mode = cfg[`MPS_CFG_MODE_MSB:0];
  assign steps_per_rev = cfg[31:`MPS_CFG_SPR_LSB];

  // Target kept for absolute and relative moves
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      target <= 32'sh0;
    // shift target by the amount cleared
    end else if (pif.zero_req) begin
      target <= target - pif.step_cnt;
    // shift target by the step jump, not reset
    end else if (pif.set_position_cmd_req && !pif.ign_pos) begin
      target <= target + (pif.new_step - pif.step_cnt);
    end else if (cmd_wr && !bad_chk && new_code == MPS_CMD_MOVE) begin
      target <= arg_pos;
    end else if (cmd_wr && !bad_chk && new_code == MPS_CMD_RELATIVE_MOVE_CMD) begin
      target <= target + arg_pos;
    end
  end

  // Movement command strobe to the motion generator
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cmd_pulse <= 1'b0;
      cmd_code <= MPS_CMD_UNKNOWN;
    end else begin
      cmd_pulse <= cmd_wr && !bad_chk && is_move;
      if (cmd_wr && !bad_chk && is_move) cmd_code <= new_code;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cmd_state <= MPS_CMD_UNKNOWN;
      cmd_running <= 1'b0;
      cmd_success <= 1'b1;
    end else if (cmd_wr && !bad_chk && is_move) begin
      cmd_state <= new_code;
      cmd_running <= 1'b1;
      cmd_success <= 1'b1;
    end else if (move_done && cmd_running) begin
      cmd_running <= 1'b0;
      cmd_success <= move_ok;
    end
  end

  // encoder state moves only after statistics while moving
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      enc_state <= MPS_ENC_UNKNOWN;
      enc_seen <= MPS_ENC_UNKNOWN;
      enc_cnt_stat <= 16'h0;
    end else if (moving) begin
      enc_seen <= enc_candidate;
      if (enc_candidate != enc_seen || enc_candidate == enc_state) begin
        enc_cnt_stat <= 16'h0;
      end else if (enc_cnt_stat == `MPS_ENC_STATS - 16'd1) begin
        enc_state <= enc_seen;
        enc_cnt_stat <= 16'h0;
      end else begin
        enc_cnt_stat <= enc_cnt_stat + 16'h1;
      end
    end
  end

  genvar gw;
  generate
    for (gw = 0; gw < 2; gw++) begin : g_wind
      assign wind_state[2*gw+1:2*gw] = !wind_valid[gw] ? MPS_WND_UNKNOWN :
        wind_low_z[gw] ? MPS_WND_SHORT : wind_high_r[gw] ? MPS_WND_OPEN : MPS_WND_OK;
    end
  endgenerate

  always_comb begin
    prim_pos = pif.step_cnt;
    prim_primary_microstep_count = pif.primary_microstep_count_cnt;
    sec_pos = pif.enc_cnt;
    case (motor_mode)
      MPS_MODE_LEADENC: begin
        prim_pos = pif.enc_cnt;
        prim_primary_microstep_count = 16'h0;
        sec_pos = pif.step_cnt;
      end
      MPS_MODE_ENCFB: sec_pos = pif.step_cnt;
      MPS_MODE_DC: sec_pos = 32'sh0;
      default: ;
    endcase
  end

  mps_flags u_flags (
    .hclk(hclk),
    .hresetn(hresetn),
    .clr_sticky(cmd_wr && !bad_chk && new_code == MPS_CMD_FSTOP),
    .proto_evt(proto_evt),
    .alarm_lvl(alarm_lvl),
    .crit_lvl(crit_lvl),
    .swap_evt(swap_evt),
    .desync_lvl(desync_lvl),
    .corr_en(cfg[`MPS_CFG_CORR_BIT]),
    .flags(flags)
  );

  // snapshot every field on status request
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      snap_move <= 32'h0000_0200;
      snap_pos <= 32'sh0;
      snap_primary_microstep_count <= 16'h0;
      snap_sec <= 32'sh0;
      snap_speed <= 32'sh0;
      snap_uspeed <= 16'h0;
      snap_cur <= 32'h0;
      snap_volt <= 32'h0;
      snap_temp <= 16'sh0;
      snap_flags <= '0;
    end else if (read_status_cmd_req) begin
      snap_move <= {8'h0, wind_state, 1'b0, enc_state, 2'h0, winding_power_field,
        2'h0, cmd_success, cmd_running, cmd_state, 1'b0, backlash_active, speed_reached, moving};
      snap_pos <= prim_pos;
      snap_primary_microstep_count <= prim_primary_microstep_count;
      snap_sec <= sec_pos;
      snap_speed <= speed_steps;
      snap_uspeed <= (motor_mode == MPS_MODE_LEADENC) ? 16'h0 : speed_microsteps;
      snap_cur <= {usb_ma, sup_ma};
      snap_volt <= {usb_10mv, sup_10mv};
      snap_temp <= cpu_decic;
      snap_flags <= flags;
    end
  end

  // Read mux at the address phase
  always_comb begin
    case (haddr[7:0])
      `MPS_CFG_OFS: next_rdata = cfg;
      `MPS_ARG_POS_OFS: next_rdata = arg_pos;
      `MPS_ARG_PRIMARY_MICROSTEP_COUNT_OFS: next_rdata = {16'h0, arg_primary_microstep_count};
      `MPS_ARG_ENC_OFS: next_rdata = arg_enc;
      `MPS_ARG_IGN_OFS: next_rdata = {30'h0, arg_ign};
      `MPS_TARGET_OFS: next_rdata = target;
      `MPS_ST_MOVE_OFS: next_rdata = snap_move;
      `MPS_ST_POS_OFS: next_rdata = snap_pos;
      `MPS_ST_PRIMARY_MICROSTEP_COUNT_OFS: next_rdata = {16'h0, snap_primary_microstep_count};
      `MPS_ST_SEC_OFS: next_rdata = snap_sec;
      `MPS_ST_SPEED_OFS: next_rdata = snap_speed;
      `MPS_ST_USPEED_OFS: next_rdata = {16'h0, snap_uspeed};
      `MPS_ST_CUR_OFS: next_rdata = snap_cur;
      `MPS_ST_VOLT_OFS: next_rdata = snap_volt;
      `MPS_ST_TEMP_OFS: next_rdata = {{16{snap_temp[15]}}, snap_temp};
      `MPS_ST_FLAGS_OFS: next_rdata = {18'h0, snap_flags};
      default: next_rdata = 32'h0;
    endcase
  end

  // Read data register
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h0;
    end else if (hready && hsel && htrans[1] && !hwrite) begin
      hrdata <= next_rdata;
    end
  end

  // zero shifts target by the cleared count
  AST_ZERO_TARGET: assert property (@(posedge hclk) disable iff (!hresetn)
    pif.zero_req |=> target == $past(target) - $past(pif.step_cnt))
    else $error("zero did not shift target");
  AST_SET_POSITION_CMD_TARGET: assert property (@(posedge hclk) disable iff (!hresetn)
    (pif.set_position_cmd_req && !pif.ign_pos && !pif.zero_req) |=> target == $past(target) + $past(arg_pos) - $past(pif.step_cnt))
    else $error("set-position moved the end point");
  // completion takes result from the motion generator
  AST_RESULT: assert property (@(posedge hclk) disable iff (!hresetn)
    (move_done && cmd_running && !cmd_wr) |=> (!cmd_running && cmd_success == $past(move_ok)))
    else $error("completion result wrong");
  // no encoder state change while stationary
  AST_ENC_STILL: assert property (@(posedge hclk) disable iff (!hresetn)
    !moving |=> $stable(enc_state))
    else $error("encoder state changed at standstill");
  // unknown code raises the flag next cycle
  AST_ERRC: assert property (@(posedge hclk) disable iff (!hresetn)
    proto_evt[`MPS_FLG_ERRC] |=> flags[`MPS_FLG_ERRC])
    else $error("unknown command not flagged");
  AST_SNAP: assert property (@(posedge hclk) disable iff (!hresetn)
    read_status_cmd_req |=> (snap_flags == $past(flags) && snap_sec == $past(sec_pos)))
    else $error("snapshot incoherent");

  COV_ZERO_MOVING: cover property (@(posedge hclk) disable iff (!hresetn) pif.zero_req && moving);
  COV_SET_POSITION_CMD: cover property (@(posedge hclk) disable iff (!hresetn) pif.set_position_cmd_req);
  COV_FAIL: cover property (@(posedge hclk) disable iff (!hresetn) move_done && cmd_running && !move_ok);
  COV_READ_STATUS_CMD: cover property (@(posedge hclk) disable iff (!hresetn) read_status_cmd_req);
endmodule // mps_top
`default_nettype wire

// file: testbench/motion_position_status_unit_tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "mps_map.svh"
module motion_position_status_unit_tb;
  import mps_pkg::*;
  logic hclk = 0, hresetn = 0, hready, hwrite, cmd_pulse;
  logic [31:0] haddr, hwdata, hrdata, target;
  logic [1:0] htrans, motor_mode;
  logic [3:0] cmd_code;
  logic [15:0] steps_per_rev;
  logic uu = 0, ue = 0, mv = 0, done = 0, ok = 0, swp = 0;
  logic [7:0] crit = 8'h0;
  logic ud = 0, ed = 0, sr = 0, bl = 0, alm = 0, dsy = 0;
  logic [31:0] spd = 32'h0;
  logic [15:0] usp = 16'h0, sma = 16'h0, uma = 16'h0, smv = 16'h0, umv = 16'h0, tmp = 16'h0;
  logic [1:0] pwr = 2'h2, lz = 2'h0, hr = 2'h0, wv = 2'h0;
  logic [2:0] ec = 3'h0;
  int n_errors = 0, checks_done = 0;
  // Clock, 25 ns period
  always #12.5 hclk = ~hclk;
  mps_host h (.hclk(hclk), .hready(hready), .hrdata(hrdata), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hwdata(hwdata));
  mps_top DUT (.hclk(hclk), .hresetn(hresetn), .hsel(1'b1), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
    .hreadyout(hready), .hresp(), .primary_microstep_count_up(uu), .primary_microstep_count_dn(ud), .enc_up(ue), .enc_dn(ed),
    .moving(mv), .speed_reached(sr), .backlash_active(bl), .move_done(done), .move_ok(ok),
    .speed_steps(spd), .speed_microsteps(usp), .winding_power_field(pwr),
    .enc_candidate(ec), .wind_low_z(lz), .wind_high_r(hr), .wind_valid(wv),
    .sup_ma(sma), .usb_ma(uma), .sup_10mv(smv), .usb_10mv(umv), .cpu_decic(tmp),
    .alarm_lvl(alm), .crit_lvl(crit), .swap_evt(swp), .desync_lvl(dsy), .cmd_pulse(cmd_pulse),
    .cmd_code(cmd_code), .target(target), .motor_mode(motor_mode), .steps_per_rev(steps_per_rev));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_errors++;
      $display("unexpected at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] q;
    h.xfer(1'b0, a, 32'h0, q);
    chk(q, e);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    h.xfer(1'b1, a, d, q);
  endtask
  task automatic pulse_counts(input int n);
    uu <= 1'b1;
    ue <= 1'b1;
    repeat (n) @(posedge hclk);
    uu <= 1'b0;
    ue <= 1'b0;
    @(posedge hclk);
  endtask
  task automatic test_reset;
    wr(`MPS_CMD_OFS, 32'hb);
    rd(`MPS_ST_MOVE_OFS, 32'h12200);
    rd(`MPS_TARGET_OFS, 32'h0);
    $display("test_reset done");
  endtask
  task automatic test_zero;
    wr(`MPS_ARG_POS_OFS, 32'd1000);
    wr(`MPS_CMD_OFS, 32'h1);
    pulse_counts(512);
    wr(`MPS_CMD_OFS, 32'h9);
    rd(`MPS_TARGET_OFS, 32'd998);
    mv <= 1'b1;
    wr(`MPS_CMD_OFS, 32'hb);
    rd(`MPS_ST_POS_OFS, 32'h0);
    rd(`MPS_ST_SEC_OFS, 32'h0);
    rd(`MPS_ST_MOVE_OFS, 32'h12311);
    mv <= 1'b0;
    done <= 1'b1;
    @(posedge hclk);
    done <= 1'b0;
    wr(`MPS_CMD_OFS, 32'hb);
    rd(`MPS_ST_MOVE_OFS, 32'h12010);
    $display("test_zero done");
  endtask
  task automatic test_setpos;
    pulse_counts(4);
    wr(`MPS_ARG_POS_OFS, 32'd5);
    wr(`MPS_ARG_PRIMARY_MICROSTEP_COUNT_OFS, 32'd3);
    wr(`MPS_ARG_ENC_OFS, 32'd9);
    wr(`MPS_ARG_IGN_OFS, 32'h2);
    wr(`MPS_CMD_OFS, 32'ha);
    rd(`MPS_TARGET_OFS, 32'd1003);
    wr(`MPS_CMD_OFS, 32'hb);
    rd(`MPS_ST_POS_OFS, 32'd5);
    rd(`MPS_ST_PRIMARY_MICROSTEP_COUNT_OFS, 32'd3);
    rd(`MPS_ST_SEC_OFS, 32'd4);
    $display("test_setpos done");
  endtask
  task automatic test_flags;
    crit <= 8'h01;
    swp <= 1'b1;
    wr(`MPS_CMD_OFS, 32'hc);
    swp <= 1'b0;
    wr(`MPS_CMD_OFS, 32'h101);
    wr(`MPS_CFG_OFS, 32'h0);
    wr(`MPS_CMD_OFS, 32'hb);
    rd(`MPS_ST_FLAGS_OFS, 32'h1017);
    wr(`MPS_CMD_OFS, 32'h6);
    wr(`MPS_CMD_OFS, 32'hb);
    rd(`MPS_ST_FLAGS_OFS, 32'h10);
    $display("test_flags done");
  endtask
  task automatic test_status;
    ud <= 1'b1;
    ed <= 1'b1;
    repeat (4) @(posedge hclk);
    ud <= 1'b0;
    ed <= 1'b0;
    sr <= 1'b1;
    bl <= 1'b1;
    pwr <= 2'h1;
    wv <= 2'h3;
    lz <= 2'h1;
    hr <= 2'h2;
    spd <= 32'h0000_0123;
    usp <= 16'h0045;
    sma <= 16'h0102;
    uma <= 16'h0304;
    smv <= 16'h0506;
    umv <= 16'h0708;
    tmp <= 16'hfff6;
    alm <= 1'b1;
    dsy <= 1'b1;
    wr(`MPS_CMD_OFS, 32'hb);
    rd(`MPS_ST_MOVE_OFS, 32'h711366);
    rd(`MPS_ST_POS_OFS, 32'd4);
    rd(`MPS_ST_PRIMARY_MICROSTEP_COUNT_OFS, 32'd255);
    rd(`MPS_ST_SEC_OFS, 32'h0);
    rd(`MPS_ST_SPEED_OFS, 32'h123);
    rd(`MPS_ST_USPEED_OFS, 32'h45);
    rd(`MPS_ST_CUR_OFS, 32'h0304_0102);
    rd(`MPS_ST_VOLT_OFS, 32'h0708_0506);
    rd(`MPS_ST_TEMP_OFS, 32'hffff_fff6);
    rd(`MPS_ST_FLAGS_OFS, 32'h2018);
    chk({28'h0, cmd_code}, 32'h6);
    $display("test_status done");
  endtask
  task automatic test_done;
    $display("checks %0d, errors %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // Main sequence
  initial begin
    repeat (4) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    test_reset;
    test_zero;
    test_setpos;
    test_flags;
    test_status;
    test_done;
  end
  // Watchdog
  initial begin
    #200000;
    n_errors++;
    test_done;
  end
endmodule // motion_position_status_unit_tb
`default_nettype wire

// file: testbench/mps_host.sv
`timescale 1ns/1ps
`default_nettype none
module mps_host (
  input wire logic hclk,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  output logic [31:0] haddr,
  output logic [1:0] htrans,
  output logic hwrite,
  output logic [31:0] hwdata
);
  // Bus idle at time zero
  initial begin
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hwdata = 32'h0;
  end
  // One single word transfer, held until hready
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    haddr <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= w;
    @(posedge hclk);
    while (!hready) @(posedge hclk);
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge hclk);
    while (!hready) @(posedge hclk);
    q = hrdata;
  endtask
endmodule // mps_host
`default_nettype wire
